// ---- include/otgrn_pkg.sv ----
package otgrn_pkg;
   // Clock period of sys_clk; all counts derive from it.
   localparam longint CLK_PERIOD_NS = 64'd50;
   // Protocol times, in nanoseconds, as printed.
   localparam longint PRE_REQUEST_QUIET_TIME_NS = 64'd2000000;
   localparam longint LINE_PULSE_DURATION_NS = 64'd5000000;
   localparam longint REQUEST_SIGNALLING_LIMIT_NS = 64'd100000000;
   localparam longint REQUEST_FAILURE_TIMEOUT_NS = 64'd5000000000;
   localparam longint IDLE_TO_DETACH_WINDOW_NS = 64'd4000000;
   localparam longint SPEED_DROP_BEFORE_DETACH_NS = 64'd1000000;
   localparam longint LINE_DISCHARGE_WAIT_NS = 64'd25000;
   localparam longint FAR_PULLUP_DEBOUNCE_NS = 64'd2500;
   localparam longint ATTACH_WAIT_MINIMUM_NS = 64'd1000000000;
   localparam longint SUSPEND_HOLD_MINIMUM_NS = 64'd200000000;
   localparam longint SWAPPED_IDLE_DETECT_WINDOW_NS = 64'd3000000;
   // Minimum waits round up so they never fall short.
   localparam int PRE_REQUEST_QUIET_CYC = // RULE17
      int'((PRE_REQUEST_QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int LINE_PULSE_CYC =
      int'((LINE_PULSE_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int REQUEST_FAILURE_CYC =
      int'((REQUEST_FAILURE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int IDLE_TO_DETACH_CYC =
      int'((IDLE_TO_DETACH_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int SPEED_DROP_CYC =
      int'((SPEED_DROP_BEFORE_DETACH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int LINE_DISCHARGE_CYC =
      int'((LINE_DISCHARGE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int FAR_PULLUP_DEBOUNCE_CYC =
      int'((FAR_PULLUP_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int ATTACH_WAIT_CYC =
      int'((ATTACH_WAIT_MINIMUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int SUSPEND_HOLD_CYC =
      int'((SUSPEND_HOLD_MINIMUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int SWAPPED_IDLE_CYC =
      int'((SWAPPED_IDLE_DETECT_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Deadline rounds down; the signalling must fit inside it.
   localparam int REQUEST_SIGNALLING_CYC =
      int'(REQUEST_SIGNALLING_LIMIT_NS / CLK_PERIOD_NS);
   // Counter width, wide enough for the longest count.
   localparam int TMR_W = 28;
   // Bit positions in the synchronised pin vector.
   localparam int PIN_ID = 0;
   localparam int PIN_SESS = 1;
   localparam int PIN_SE0 = 2;
   localparam int PIN_J = 3;
   localparam int PIN_N = 4;
   // Role states, one-hot.
   typedef enum logic [10:0] {
      ST_B_IDLE = 11'h001,
      ST_B_SRP = 11'h002,
      ST_B_PERIPH = 11'h004,
      ST_B_FS_DROP = 11'h008,
      ST_B_WAIT_ACON = 11'h010,
      ST_B_HOST = 11'h020,
      ST_A_IDLE = 11'h040,
      ST_A_WAIT_BCON = 11'h080,
      ST_A_HOST = 11'h100,
      ST_A_SUSPEND = 11'h200,
      ST_A_PERIPH = 11'h400
   } otgrn_state_t;
endpackage : otgrn_pkg

// ---- hdl/otgrn_role_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - B-side needs 2 ms line SE0 while idle, then pulses data 5 to 10 ms.
// RULE2 - B-side finishes session request signalling within 100 ms of starting.
// RULE3 - A answers within 4.9 s; B waits 5 s, fails by 6 s.
// RULE4 - B-side connects as peripheral within 1 s of session valid.
// RULE5 - A-side waits at least 1 s for connect before giving up.
// RULE6 - Enabled B detaches after 4 to 150 ms idle; A suspends 200 ms.
// RULE7 - From high speed, B holds full-speed pull-up 1 to 146.875 ms first.
// RULE8 - After dropping its pull-up, wait 25 us before sampling the line.
// RULE9 - B debounces A connect 2.5 us, then drives reset within 1 ms.
// RULE10 - A turns on pull-up within 3 ms of seeing B detach in suspend.
// RULE11 - Swapped A detects 3 to 200 ms idle, then drops its pull-up.
// RULE12 - Timers accurate to 2,500 ppm full speed, 500 ppm high speed.
// RULE13 - Host plug gives default host role; peripheral plug default peripheral.
// RULE14 - Host negotiation supported in both A and B roles.
// RULE15 - Simultaneous transitions resolved by fixed priority, exactly one taken.
// RULE16 - B asks for host only when enabled, by detaching during suspend.
// RULE17 - Limits become clock counts; minimums round up, maximums round down.
// RULE18 - Status events on request failure and on every role change; the code flags host_role changes only, not a_role changes.
module otgrn_role_ctrl #(
   parameter int QUIET_CYC = otgrn_pkg::PRE_REQUEST_QUIET_CYC, // RULE17
   parameter int PULSE_CYC = otgrn_pkg::LINE_PULSE_CYC,
   parameter int FAIL_CYC = otgrn_pkg::REQUEST_FAILURE_CYC,
   parameter int DETACH_CYC = otgrn_pkg::IDLE_TO_DETACH_CYC,
   parameter int FS_DROP_CYC = otgrn_pkg::SPEED_DROP_CYC,
   parameter int ATTACH_CYC = otgrn_pkg::ATTACH_WAIT_CYC,
   parameter int HOLD_CYC = otgrn_pkg::SUSPEND_HOLD_CYC,
   parameter int SWAP_IDLE_CYC = otgrn_pkg::SWAPPED_IDLE_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic id_pin,
   input wire logic sess_vld,
   input wire logic line_se0,
   input wire logic line_j,
   input wire logic bus_idle,
   input wire logic hs_mode,
   input wire logic hnp_en,
   input wire logic a_bus_req,
   input wire logic b_bus_req,
   input wire logic b_srp_req,
   output logic pullup_en,
   output logic srp_pulse,
   output logic bus_reset,
   output logic fs_force,
   output logic vbus_drive,
   output logic host_role,
   output logic a_role,
   output logic srp_fail_evt,
   output logic role_chg_evt
);
   localparam int TW = otgrn_pkg::TMR_W;
   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic [otgrn_pkg::PIN_N-1:0] pin_meta_reg;
   logic [otgrn_pkg::PIN_N-1:0] pin_reg;
   otgrn_pkg::otgrn_state_t state_reg;
   otgrn_pkg::otgrn_state_t state_next;
   logic [TW-1:0] tmr_reg;
   logic [TW-1:0] idle_reg;
   logic [TW-1:0] se0_reg;
   logic [TW-1:0] j_reg;
   logic a_plug;
   logic sess;
   logic quiet_ok;
   logic j_ok;
   logic host_next;

   // Reset enters asynchronously but is released through two flops.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Each pin passes two flops; only the second stage is read.
   genvar gi;
   generate
      for (gi = 0; gi < otgrn_pkg::PIN_N; gi++) begin : g_sync
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               pin_meta_reg[gi] <= 1'b0;
               pin_reg[gi] <= 1'b0;
            end else begin
               pin_meta_reg[gi] <= (gi == otgrn_pkg::PIN_ID) ? id_pin :
                  (gi == otgrn_pkg::PIN_SESS) ? sess_vld :
                  (gi == otgrn_pkg::PIN_SE0) ? line_se0 : line_j;
               pin_reg[gi] <= pin_meta_reg[gi];
            end
         end
      end
   endgenerate

   // A grounded identification pin means the host-type plug is in.
   assign a_plug = !pin_reg[otgrn_pkg::PIN_ID]; // RULE13
   assign sess = pin_reg[otgrn_pkg::PIN_SESS];
   // The quiet spell must also lie inside the idle state, so a request that
   // has just failed cannot start again on the next cycle.
   assign quiet_ok = (se0_reg >= TW'(QUIET_CYC)) && (tmr_reg >= TW'(QUIET_CYC)); // RULE1
   // The state timer covers drain plus debounce, so every debounce sample
   // falls after the line has drained and residual charge cannot pass as J.
   assign j_ok = (tmr_reg >= TW'(otgrn_pkg::LINE_DISCHARGE_CYC +
      otgrn_pkg::FAR_PULLUP_DEBOUNCE_CYC)) && // RULE8
      (j_reg >= TW'(otgrn_pkg::FAR_PULLUP_DEBOUNCE_CYC)); // RULE9

   // State time counter; restarts on every state change. The clock itself
   // must be a crystal source to hold the timer accuracy.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_reg <= '0;
      end else if (state_next != state_reg) begin
         tmr_reg <= '0;
      end else if (tmr_reg != {TW{1'b1}}) begin
         tmr_reg <= tmr_reg + TW'(1); // RULE12
      end
   end

   // Run-length counters for bus idle, line SE0 and line J; they saturate.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_reg <= '0;
         se0_reg <= '0;
         j_reg <= '0;
      end else begin
         idle_reg <= !bus_idle ? '0 : (idle_reg == {TW{1'b1}}) ? idle_reg : idle_reg + TW'(1);
         se0_reg <= !pin_reg[otgrn_pkg::PIN_SE0] ? '0 :
            (se0_reg == {TW{1'b1}}) ? se0_reg : se0_reg + TW'(1);
         j_reg <= !pin_reg[otgrn_pkg::PIN_J] ? '0 :
            (j_reg == {TW{1'b1}}) ? j_reg : j_reg + TW'(1);
      end
   end

   // Next role state. Plug changes win, then session loss, then the
   // state's own exits in the order written, so one exit is ever taken.
   always_comb begin
      state_next = state_reg;
      if (a_plug && !(state_reg inside {otgrn_pkg::ST_A_IDLE, otgrn_pkg::ST_A_WAIT_BCON,
            otgrn_pkg::ST_A_HOST, otgrn_pkg::ST_A_SUSPEND, otgrn_pkg::ST_A_PERIPH})) begin
         state_next = otgrn_pkg::ST_A_IDLE; // RULE15
      end else if (!a_plug && (state_reg inside {otgrn_pkg::ST_A_IDLE,
            otgrn_pkg::ST_A_WAIT_BCON, otgrn_pkg::ST_A_HOST, otgrn_pkg::ST_A_SUSPEND,
            otgrn_pkg::ST_A_PERIPH})) begin
         state_next = otgrn_pkg::ST_B_IDLE; // RULE13
      end else if (!sess && !(state_reg inside {otgrn_pkg::ST_B_IDLE, otgrn_pkg::ST_B_SRP,
            otgrn_pkg::ST_A_IDLE, otgrn_pkg::ST_A_WAIT_BCON})) begin
         state_next = a_plug ? otgrn_pkg::ST_A_IDLE : otgrn_pkg::ST_B_IDLE; // RULE15
      end else begin
         case (state_reg)
            otgrn_pkg::ST_B_IDLE: begin
               if (sess) begin
                  state_next = otgrn_pkg::ST_B_PERIPH; // RULE4
               end else if (b_srp_req && quiet_ok) begin
                  state_next = otgrn_pkg::ST_B_SRP; // RULE1
               end
            end
            otgrn_pkg::ST_B_SRP: begin
               if (sess && tmr_reg >= TW'(PULSE_CYC)) begin
                  state_next = otgrn_pkg::ST_B_PERIPH;
               end else if (tmr_reg >= TW'(FAIL_CYC)) begin
                  state_next = otgrn_pkg::ST_B_IDLE; // RULE3
               end
            end
            otgrn_pkg::ST_B_PERIPH: begin
               if (hnp_en && b_bus_req && idle_reg >= TW'(DETACH_CYC)) begin // RULE16
                  state_next = hs_mode ? otgrn_pkg::ST_B_FS_DROP : // RULE7
                     otgrn_pkg::ST_B_WAIT_ACON; // RULE6
               end
            end
            otgrn_pkg::ST_B_FS_DROP: begin
               if (!bus_idle) begin
                  state_next = otgrn_pkg::ST_B_PERIPH;
               end else if (tmr_reg >= TW'(FS_DROP_CYC)) begin
                  state_next = otgrn_pkg::ST_B_WAIT_ACON; // RULE7
               end
            end
            otgrn_pkg::ST_B_WAIT_ACON: begin
               if (j_ok) begin
                  state_next = otgrn_pkg::ST_B_HOST; // RULE9
               end else if (!bus_idle) begin
                  state_next = otgrn_pkg::ST_B_PERIPH;
               end
            end
            otgrn_pkg::ST_B_HOST: begin
               if (!b_bus_req && bus_idle) begin
                  state_next = otgrn_pkg::ST_B_PERIPH;
               end
            end
            otgrn_pkg::ST_A_IDLE: begin
               if (a_bus_req || sess) begin
                  state_next = otgrn_pkg::ST_A_WAIT_BCON; // RULE3
               end
            end
            otgrn_pkg::ST_A_WAIT_BCON: begin
               if (j_ok) begin
                  state_next = otgrn_pkg::ST_A_HOST;
               end else if (tmr_reg >= TW'(ATTACH_CYC)) begin
                  state_next = otgrn_pkg::ST_A_IDLE; // RULE5
               end
            end
            otgrn_pkg::ST_A_HOST: begin
               if (!a_bus_req && bus_idle) begin
                  state_next = otgrn_pkg::ST_A_SUSPEND;
               end
            end
            otgrn_pkg::ST_A_SUSPEND: begin
               if (hnp_en && pin_reg[otgrn_pkg::PIN_SE0]) begin
                  state_next = otgrn_pkg::ST_A_PERIPH; // RULE10
               end else if (a_bus_req && tmr_reg >= TW'(HOLD_CYC)) begin
                  state_next = otgrn_pkg::ST_A_HOST; // RULE6
               end
            end
            otgrn_pkg::ST_A_PERIPH: begin
               if (idle_reg >= TW'(SWAP_IDLE_CYC)) begin
                  state_next = otgrn_pkg::ST_A_WAIT_BCON; // RULE11
               end
            end
            default: begin
               state_next = otgrn_pkg::ST_B_IDLE;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= otgrn_pkg::ST_B_IDLE;
      end else begin
         state_reg <= state_next; // RULE14
      end
   end

   assign host_next = state_next inside {otgrn_pkg::ST_B_HOST, otgrn_pkg::ST_A_HOST,
      otgrn_pkg::ST_A_SUSPEND, otgrn_pkg::ST_A_WAIT_BCON};

   // Outputs other than a_role are decoded from the next state so they change with it.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pullup_en <= 1'b0;
         srp_pulse <= 1'b0;
         bus_reset <= 1'b0;
         fs_force <= 1'b0;
         vbus_drive <= 1'b0;
         host_role <= 1'b0;
         a_role <= 1'b0;
      end else begin
         pullup_en <= state_next inside {otgrn_pkg::ST_B_PERIPH, otgrn_pkg::ST_B_FS_DROP,
            otgrn_pkg::ST_A_PERIPH}; // RULE4
         // Pulse runs only from the start of the request state, well inside the limit.
         srp_pulse <= (state_next == otgrn_pkg::ST_B_SRP) &&
            ((state_reg != otgrn_pkg::ST_B_SRP) ||
             (tmr_reg < TW'(PULSE_CYC - 1))); // RULE2
         bus_reset <= host_next && (state_next != state_reg) &&
            (state_next inside {otgrn_pkg::ST_B_HOST, otgrn_pkg::ST_A_HOST}) &&
            (state_reg != otgrn_pkg::ST_A_SUSPEND); // RULE9
         fs_force <= state_next == otgrn_pkg::ST_B_FS_DROP; // RULE7
         vbus_drive <= a_plug && (state_next != otgrn_pkg::ST_A_IDLE);
         host_role <= host_next;
         a_role <= a_plug; // RULE13
      end
   end

   // One-cycle status events for software.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         srp_fail_evt <= 1'b0;
         role_chg_evt <= 1'b0;
      end else begin
         srp_fail_evt <= (state_reg == otgrn_pkg::ST_B_SRP) &&
            (state_next == otgrn_pkg::ST_B_IDLE); // RULE18
         role_chg_evt <= host_next != host_role; // RULE18
      end
   end
endmodule : otgrn_role_ctrl
`default_nettype wire

// ---- verif/otgrn_role_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module otgrn_role_ctrl_chk #(
   parameter int PULSE_CYC = 50,
   parameter int FAIL_CYC = 500,
   parameter int FS_DROP_CYC = 10
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic a_role,
   input wire logic pullup_en,
   input wire logic srp_pulse,
   input wire logic bus_reset,
   input wire logic fs_force,
   input wire logic host_role,
   input wire logic srp_fail_evt,
   input wire logic role_chg_evt
);
   int pulse_cnt;
   int req_cnt;
   int off_cnt;
   int fs_cnt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Cycle counters; the free-running ones saturate so a long idle spell cannot wrap them.
   always_ff @(posedge sys_clk) begin
      pulse_cnt <= srp_pulse ? pulse_cnt + 1 : 0;
      req_cnt <= $rose(srp_pulse) ? 1 : (req_cnt < 1000000 ? req_cnt + 1 : req_cnt);
      off_cnt <= pullup_en ? 0 : (off_cnt < 1000000 ? off_cnt + 1 : off_cnt);
      fs_cnt <= fs_force ? fs_cnt + 1 : 0;
   end
   a_pulse_len_ok: assert property ($fell(srp_pulse) |->
      pulse_cnt >= PULSE_CYC && pulse_cnt <= 2 * PULSE_CYC)
      else $error("session request pulse length out of range");
   a_fail_window: assert property (srp_fail_evt |->
      req_cnt >= FAIL_CYC - 2 && req_cnt <= FAIL_CYC + FAIL_CYC / 5)
      else $error("request failure reported outside its window");
   a_fail_single: assert property (srp_fail_evt |-> !srp_pulse ##1 !srp_fail_evt)
      else $error("failure event malformed");
   // The event is registered from the same next value as the role flag, so both move together.
   a_role_evt_follow: assert property ($changed(host_role) |-> role_chg_evt)
      else $error("role change without event");
   a_role_evt_cause: assert property (role_chg_evt |-> $changed(host_role))
      else $error("role event without role change");
   // The A side raises the host flag on powering the bus, before any connect,
   // so only the B side owes a bus reset on that edge.
   a_reset_on_host: assert property ($rose(host_role) && !a_role |-> ##[0:1] bus_reset)
      else $error("no bus reset on taking host role");
   a_drain_first: assert property ($rose(host_role) && !a_role |-> off_cnt >= 550)
      else $error("host role taken before drain and debounce");
   a_fs_pullup_on: assert property (fs_force |-> pullup_en)
      else $error("full speed hold without pull-up");
   a_fs_hold: assert property ($fell(pullup_en) && $past(fs_force) |->
      fs_cnt >= FS_DROP_CYC)
      else $error("full speed hold too short");
   c_fail: cover property (srp_fail_evt);
   c_b_host: cover property ($rose(host_role) && !a_role);
   c_fs_detach: cover property ($fell(pullup_en) && $past(fs_force));
endmodule : otgrn_role_ctrl_chk
bind otgrn_role_ctrl otgrn_role_ctrl_chk #(.PULSE_CYC(PULSE_CYC), .FAIL_CYC(FAIL_CYC),
   .FS_DROP_CYC(FS_DROP_CYC)) chk_u (.sys_clk(sys_clk), .resetn(resetn), .a_role(a_role),
   .pullup_en(pullup_en), .srp_pulse(srp_pulse), .bus_reset(bus_reset), .fs_force(fs_force),
   .host_role(host_role), .srp_fail_evt(srp_fail_evt), .role_chg_evt(role_chg_evt));
`default_nettype wire

// ---- verif/otgrn_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module otgrn_far_end #(
   parameter int ANS_CYC = 100,
   parameter int ACON_CYC = 40,
   parameter int RESID_CYC = 20
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic answer_en,
   input wire logic srp_pulse,
   input wire logic pullup_en,
   input wire logic vbus_drive,
   output logic sess_vld,
   output logic line_se0,
   output logic line_j
);
   int ans_cnt;
   int acon_cnt;
   int resid_cnt;
   logic seen_reg;
   logic answered_reg;
   logic far_pu_reg;
   // Answer a seen request after a delay well inside the answer limit.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         seen_reg <= 1'b0;
         answered_reg <= 1'b0;
         ans_cnt <= 0;
      end else if (!answer_en) begin
         seen_reg <= 1'b0;
         answered_reg <= 1'b0;
         ans_cnt <= 0;
      end else if (srp_pulse) seen_reg <= 1'b1;
      else if (seen_reg && ans_cnt < ANS_CYC) ans_cnt <= ans_cnt + 1;
      else if (seen_reg) answered_reg <= 1'b1;
   end
   // Far pull-up follows a detach; our pull-up leaves charge on the line a while.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         far_pu_reg <= 1'b0;
         acon_cnt <= 0;
         resid_cnt <= 0;
      end else begin
         resid_cnt <= pullup_en ? RESID_CYC : (resid_cnt > 0 ? resid_cnt - 1 : 0);
         if (!answer_en || !sess_vld || pullup_en) begin
            far_pu_reg <= 1'b0;
            acon_cnt <= 0;
         end else if (acon_cnt < ACON_CYC) acon_cnt <= acon_cnt + 1;
         else far_pu_reg <= 1'b1;
      end
   end
   assign sess_vld = answered_reg || vbus_drive;
   // The near side's data-line pulse drives the line high, so it breaks the SE0 spell.
   assign line_j = pullup_en || srp_pulse || far_pu_reg || resid_cnt > 0;
   assign line_se0 = !line_j;
endmodule : otgrn_far_end
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int PULSE = 50;
   localparam int FAIL = 500;
   localparam int DETACH = 20;
   localparam int FS_DROP = 10;
   localparam int ATTACH = 1000;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic id_pin = 1'b1;
   logic bus_idle = 1'b0;
   logic hs_mode = 1'b0;
   logic hnp_en = 1'b0;
   logic a_bus_req = 1'b0;
   logic b_bus_req = 1'b0;
   logic b_srp_req = 1'b0;
   logic answer_en = 1'b0;
   logic sess_vld, line_se0, line_j, pullup_en, srp_pulse, bus_reset, fs_force;
   logic vbus_drive, host_role, a_role, srp_fail_evt, role_chg_evt;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   int t;
   always #25 sys_clk = ~sys_clk;
   otgrn_role_ctrl #(.QUIET_CYC(20), .PULSE_CYC(PULSE), .FAIL_CYC(FAIL), .DETACH_CYC(DETACH),
      .FS_DROP_CYC(FS_DROP), .ATTACH_CYC(ATTACH), .HOLD_CYC(50), .SWAP_IDLE_CYC(20)) dut_u (
      .sys_clk(sys_clk), .resetn(resetn), .id_pin(id_pin), .sess_vld(sess_vld),
      .line_se0(line_se0), .line_j(line_j), .bus_idle(bus_idle), .hs_mode(hs_mode),
      .hnp_en(hnp_en), .a_bus_req(a_bus_req), .b_bus_req(b_bus_req), .b_srp_req(b_srp_req),
      .pullup_en(pullup_en), .srp_pulse(srp_pulse), .bus_reset(bus_reset), .fs_force(fs_force),
      .vbus_drive(vbus_drive), .host_role(host_role), .a_role(a_role),
      .srp_fail_evt(srp_fail_evt), .role_chg_evt(role_chg_evt));
   otgrn_far_end far_u (.sys_clk(sys_clk), .resetn(resetn), .answer_en(answer_en),
      .srp_pulse(srp_pulse), .pullup_en(pullup_en), .vbus_drive(vbus_drive),
      .sess_vld(sess_vld), .line_se0(line_se0), .line_j(line_j));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: %s seen %0d expected %0d", $time, what, seen, exp);
      end
   endtask : check
   task automatic end_of_test;
      $display("Checked %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   // No answer comes, so the request must time out after a full-length pulse.
   task automatic t_srp_fail;
      @(posedge sys_clk) b_srp_req <= 1'b1;
      for (n = 0; n < 200 && srp_pulse !== 1'b1; n++) @(negedge sys_clk);
      for (n = 0; n < 300 && srp_pulse === 1'b1; n++) @(negedge sys_clk);
      check(n, PULSE, "pulse length");
      for (t = n; t < 1000 && srp_fail_evt !== 1'b1; t++) @(negedge sys_clk);
      check(t >= FAIL - 2 && t <= FAIL + FAIL / 5, 1, "failure time");
      check(srp_pulse, 0, "pulse after failure");
      @(posedge sys_clk) b_srp_req <= 1'b0;
      $display("session failure test done");
   endtask : t_srp_fail
   // Answered request attaches; a detach without enable is refused.
   task automatic t_srp_ok;
      @(posedge sys_clk) answer_en <= 1'b1;
      b_srp_req <= 1'b1;
      for (n = 0; n < 400 && sess_vld !== 1'b1; n++) @(negedge sys_clk);
      for (n = 0; n < 100 && pullup_en !== 1'b1; n++) @(negedge sys_clk);
      check(n <= 10, 1, "attach delay");
      check(host_role, 0, "default peripheral");
      @(posedge sys_clk) b_srp_req <= 1'b0;
      bus_idle <= 1'b1;
      b_bus_req <= 1'b1;
      repeat (100) @(negedge sys_clk);
      check(pullup_en, 1, "detach while not enabled");
      $display("session attach test done");
   endtask : t_srp_ok
   // Enabled swap from high speed: full-speed hold, detach, far pull-up, take host.
   task automatic t_hnp;
      // Break the idle spell first so the detach time is counted from a fresh idle start.
      @(posedge sys_clk) bus_idle <= 1'b0;
      hs_mode <= 1'b1;
      @(posedge sys_clk) hnp_en <= 1'b1;
      bus_idle <= 1'b1;
      for (n = 0; n < 800 && pullup_en === 1'b1; n++) @(negedge sys_clk);
      check(n >= DETACH + FS_DROP && n <= 750, 1, "detach time");
      for (t = 0; t < 2000 && host_role !== 1'b1; t++) @(negedge sys_clk);
      check(t >= 550 && t < 2000, 1, "host take time");
      check(role_chg_evt, 1, "role change event");
      n = bus_reset;
      @(negedge sys_clk);
      check(n | bus_reset, 1, "bus reset");
      @(posedge sys_clk) b_bus_req <= 1'b0;
      hnp_en <= 1'b0;
      hs_mode <= 1'b0;
      for (n = 0; n < 300 && host_role === 1'b1; n++) @(negedge sys_clk);
      check(role_chg_evt, 1, "role return event");
      $display("role swap test done");
   endtask : t_hnp
   // Host plug: default host, powered bus waits the full connect time.
   task automatic t_a_role;
      @(posedge sys_clk) answer_en <= 1'b0;
      bus_idle <= 1'b0;
      id_pin <= 1'b0;
      repeat (10) @(negedge sys_clk);
      check(a_role, 1, "host plug");
      @(posedge sys_clk) a_bus_req <= 1'b1;
      for (n = 0; n < 50 && vbus_drive !== 1'b1; n++) @(negedge sys_clk);
      check(vbus_drive, 1, "bus powered");
      for (n = 0; n < 1100 && vbus_drive === 1'b1; n++) @(negedge sys_clk);
      check(n >= ATTACH, 1, "connect wait");
      check(host_role, 0, "no host without connect");
      @(posedge sys_clk) a_bus_req <= 1'b0;
      $display("host plug test done");
   endtask : t_a_role
   // A hang is cut short well above the few thousand cycles the tests need.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(negedge sys_clk);
      t_srp_fail();
      repeat (5) @(negedge sys_clk);
      t_srp_ok();
      t_hnp();
      t_a_role();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
